//--- design/prd_pkg.sv
// prd_pkg: shared constants, field layout and types of the predriver register bank
// assumes: one system clock at CLK_KHZ; every default cycle count in prd_predriver is derived from it
package prd_pkg;
	localparam int CLK_KHZ = 250000;
	localparam int NUM_CH = 6;
	localparam int WORD_BITS = 16;
	localparam int CNT_W = 5;
	localparam int TMR_W = 24;
	localparam int FLT_BITS = 3;
	localparam int SYNC_W = 7 + 3 * NUM_CH;
	localparam logic [6:0] SYNC_INIT_HI = 7'h68;

	localparam logic [3:0] ADDR_GATE = 4'h1;
	localparam logic [3:0] ADDR_MASK = 4'h5;
	localparam int ADDR_MSB = 15;
	localparam int ADDR_LSB = 12;
	localparam int CFG_FLAG_BIT = 15;
	localparam int CH_SEL_MSB = 14;
	localparam int CH_SEL_LSB = 12;
	localparam int OLM_BIT = 6;

	localparam int RT_MSB = 11;
	localparam int RT_LSB = 10;
	localparam int NPD_BIT = 8;
	localparam int TOF_MSB = 7;
	localparam int TOF_LSB = 6;
	localparam int TON_MSB = 5;
	localparam int TON_LSB = 4;
	localparam int SB_MSB = 3;
	localparam int SB_LSB = 1;
	localparam int SG_BIT = 0;

	localparam int FF_BIT = 15;
	localparam int UV_BIT = 14;
	localparam int LR_BIT = 13;
	localparam int OT_BIT = 12;
	localparam int FR_BIT = 11;
	localparam int FLT_SG = 2;
	localparam int FLT_SB = 1;
	localparam int FLT_OL = 0;

	localparam int SHORT_RETRY_MS = 10;
	localparam int LONG_RETRY_MS = 55;
	localparam int OFF_BLANK0_US = 80;
	localparam int OFF_BLANK1_US = 140;
	localparam int OFF_BLANK2_US = 280;
	localparam int OFF_BLANK3_MS = 4;
	localparam int ON_BLANK0_US = 5;
	localparam int ON_BLANK1_US = 14;
	localparam int ON_BLANK2_US = 28;
	localparam int ON_BLANK3_US = 56;
	localparam int US_PER_MS = 1000;

	typedef struct packed {
		logic [1:0] retry_select;
		logic pulldown_disable;
		logic [1:0] off_blank_select;
		logic [1:0] on_blank_select;
		logic [2:0] battery_short_threshold;
		logic ground_short_threshold;
	} prd_cfg_s;

	localparam prd_cfg_s CFG_RESET = '0;

	typedef enum logic [2:0] {
		PRD_IDLE = 3'h1,
		PRD_FRAME = 3'h2,
		PRD_OVER = 3'h4
	} prd_spi_e;
endpackage : prd_pkg

//--- design/prd_tmr_if.sv
// prd_tmr_if: start/load/done bundle between the register bank and a timer
// assumes: start is a one-cycle pulse on mclk
`timescale 1ns/1ps
interface prd_tmr_if;
	logic start;
	logic [prd_pkg::TMR_W-1:0] load;
	logic done;

	modport owner (output start, output load, input done);
	modport timer (input start, input load, output done);
endinterface : prd_tmr_if

//--- design/prd_sync.sv
// prd_sync: three-stage input synchroniser with agreement filter
// assumes: inputs are asynchronous to mclk
`timescale 1ns/1ps
module prd_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [W-1:0] raw,
	output logic [W-1:0] clean
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// the first stage feeds only the second
	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			clean <= INIT;
		end
		else
		begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < W; i++)
				if (s2_q[i] == s3_q[i])
					clean[i] <= s3_q[i];
		end
endmodule : prd_sync

//--- design/prd_timer.sv
// prd_timer: reloadable down counter, one-cycle done pulse after load cycles
// assumes: load is at least 1; a new start restarts the count
`timescale 1ns/1ps
module prd_timer (
	input wire logic mclk,
	input wire logic rst_b,
	prd_tmr_if.timer tmr
);
	logic [prd_pkg::TMR_W-1:0] cnt_q;
	localparam logic [prd_pkg::TMR_W-1:0] ONE = 24'h000001;

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			cnt_q <= '0;
			tmr.done <= 1'b0;
		end
		else
		begin
			tmr.done <= (cnt_q == ONE) && !tmr.start;
			if (tmr.start)
				cnt_q <= tmr.load;
			else if (cnt_q != '0)
				cnt_q <= cnt_q - ONE;
		end
endmodule : prd_timer

//--- design/prd_predriver.sv
// prd_predriver: serial register bank and channel fault logic of a six-channel gate predriver
// assumes: serial pins and analog comparator flags are asynchronous; mclk far faster than the serial clock
//
// How it works
// - 16-bit words, MSB first, top nibble addresses
// - gate select at 1, fault mask at 5
// - top bit set: config write, channel in 14:12
// - gate high: select, reset pin high, no battery-short lockout
// - masked channel: faults ignored and unreported
// - open-load mask disables diagnosis where pulldown off
// - retry: upper bit 0 lockout, 10 short, 11 long
// - pulldown disable: 0 enables, 1 disables
// - off blank: 80us, 140us, 280us, 4ms
// - on blank: 5us, 14us, 28us, 56us
// - battery short threshold code drives comparator
// - ground short threshold bit drives comparator
// - writable bits clear at power-on reset
// - bit 15 flags any fault since last fault reset
// - undervoltage flag: logic or regulator supply
// - logic reset flag held until next read
// - overtemperature flag since last fault reset
// - bit 11 names the status word sent
// - channel flags in 8:0, two pages, 10:9 zero
`timescale 1ns/1ps
module prd_predriver #(
	parameter int SHORT_RETRY_CYC = prd_pkg::SHORT_RETRY_MS * prd_pkg::CLK_KHZ,
	parameter int LONG_RETRY_CYC = prd_pkg::LONG_RETRY_MS * prd_pkg::CLK_KHZ,
	parameter int OFF_BLANK0_CYC = prd_pkg::OFF_BLANK0_US * prd_pkg::CLK_KHZ / prd_pkg::US_PER_MS,
	parameter int OFF_BLANK1_CYC = prd_pkg::OFF_BLANK1_US * prd_pkg::CLK_KHZ / prd_pkg::US_PER_MS,
	parameter int OFF_BLANK2_CYC = prd_pkg::OFF_BLANK2_US * prd_pkg::CLK_KHZ / prd_pkg::US_PER_MS,
	parameter int OFF_BLANK3_CYC = prd_pkg::OFF_BLANK3_MS * prd_pkg::CLK_KHZ,
	parameter int ON_BLANK0_CYC = prd_pkg::ON_BLANK0_US * prd_pkg::CLK_KHZ / prd_pkg::US_PER_MS,
	parameter int ON_BLANK1_CYC = prd_pkg::ON_BLANK1_US * prd_pkg::CLK_KHZ / prd_pkg::US_PER_MS,
	parameter int ON_BLANK2_CYC = prd_pkg::ON_BLANK2_US * prd_pkg::CLK_KHZ / prd_pkg::US_PER_MS,
	parameter int ON_BLANK3_CYC = prd_pkg::ON_BLANK3_US * prd_pkg::CLK_KHZ / prd_pkg::US_PER_MS
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic serial_csn_b,
	input wire logic serial_clk,
	input wire logic serial_din,
	output logic serial_dout,
	output logic serial_dout_oe,
	input wire logic external_reset_low,
	input wire logic vdd_undervoltage,
	input wire logic vreg_undervoltage,
	input wire logic overtemp_detect,
	input wire logic [prd_pkg::NUM_CH-1:0] battery_short_detect,
	input wire logic [prd_pkg::NUM_CH-1:0] ground_short_detect,
	input wire logic [prd_pkg::NUM_CH-1:0] open_load_detect,
	output logic [prd_pkg::NUM_CH-1:0] gate_drive_out,
	output logic [prd_pkg::NUM_CH-1:0] pulldown_en,
	output logic [3*prd_pkg::NUM_CH-1:0] battery_short_threshold,
	output logic [prd_pkg::NUM_CH-1:0] ground_short_threshold
);
	localparam int NCH = prd_pkg::NUM_CH;
	localparam int MAX_CYC = 2 ** prd_pkg::TMR_W - 1;
	localparam logic [prd_pkg::CNT_W-1:0] FULL_CNT = 5'h10;
	localparam logic [prd_pkg::CNT_W-1:0] ONE_CNT = 5'h01;

	// a cycle count wider than the timer would wrap silently
	if (SHORT_RETRY_CYC < 1 || SHORT_RETRY_CYC > MAX_CYC || LONG_RETRY_CYC < 1 || LONG_RETRY_CYC > MAX_CYC)
	begin : g_bad_retry
		$error("retry cycle count out of timer range");
	end
	if (OFF_BLANK0_CYC < 1 || OFF_BLANK3_CYC > MAX_CYC || ON_BLANK0_CYC < 1 || ON_BLANK3_CYC > MAX_CYC)
	begin : g_bad_blank
		$error("blank cycle count out of timer range");
	end

	function automatic prd_pkg::prd_cfg_s to_cfg(input logic [prd_pkg::WORD_BITS-1:0] w);
		prd_pkg::prd_cfg_s c;
		c.retry_select = w[prd_pkg::RT_MSB:prd_pkg::RT_LSB];
		c.pulldown_disable = w[prd_pkg::NPD_BIT];
		c.off_blank_select = w[prd_pkg::TOF_MSB:prd_pkg::TOF_LSB];
		c.on_blank_select = w[prd_pkg::TON_MSB:prd_pkg::TON_LSB];
		c.battery_short_threshold = w[prd_pkg::SB_MSB:prd_pkg::SB_LSB];
		c.ground_short_threshold = w[prd_pkg::SG_BIT];
		return c;
	endfunction : to_cfg

	function automatic logic [prd_pkg::TMR_W-1:0] blank_cycles(input logic on, input prd_pkg::prd_cfg_s c);
		int n;
		n = 0;
		if (on)
			case (c.on_blank_select)
				2'h0: n = ON_BLANK0_CYC;
				2'h1: n = ON_BLANK1_CYC;
				2'h2: n = ON_BLANK2_CYC;
				default: n = ON_BLANK3_CYC;
			endcase
		else
			case (c.off_blank_select)
				2'h0: n = OFF_BLANK0_CYC;
				2'h1: n = OFF_BLANK1_CYC;
				2'h2: n = OFF_BLANK2_CYC;
				default: n = OFF_BLANK3_CYC;
			endcase
		return prd_pkg::TMR_W'(n);
	endfunction : blank_cycles

	function automatic logic [prd_pkg::WORD_BITS-1:0] status_word(
		input logic page,
		input logic ff,
		input logic uv,
		input logic lr,
		input logic ot,
		input logic [3*NCH-1:0] rep
	);
		logic [prd_pkg::WORD_BITS-1:0] w;
		w = '0;
		w[prd_pkg::FF_BIT] = ff;
		w[prd_pkg::UV_BIT] = uv;
		w[prd_pkg::LR_BIT] = lr;
		w[prd_pkg::OT_BIT] = ot;
		w[prd_pkg::FR_BIT] = page;
		w[3*prd_pkg::FLT_BITS-1:0] = page ? rep[3*NCH-1:3*prd_pkg::FLT_BITS] : rep[3*prd_pkg::FLT_BITS-1:0];
		return w;
	endfunction : status_word

	// pin synchronisers
	logic [prd_pkg::SYNC_W-1:0] pins_s;
	logic csn_s;
	logic sck_s;
	logic si_s;
	logic ext_high_s;
	logic uvd_s;
	logic uvr_s;
	logic ot_s;
	logic [NCH-1:0] bsd_s;
	logic [NCH-1:0] gsd_s;
	logic [NCH-1:0] old_s;

	prd_sync #(
		.W(prd_pkg::SYNC_W),
		.INIT({prd_pkg::SYNC_INIT_HI, {(3*NCH){1'b0}}})
	) u_sync (
		.mclk(mclk),
		.rst_b(rst_b),
		.raw({serial_csn_b, serial_clk, serial_din, external_reset_low, vdd_undervoltage,
			vreg_undervoltage, overtemp_detect, battery_short_detect, ground_short_detect, open_load_detect}),
		.clean(pins_s)
	);

	assign {csn_s, sck_s, si_s, ext_high_s, uvd_s, uvr_s, ot_s, bsd_s, gsd_s, old_s} = pins_s;

	// serial frame
	logic csn_prev_q;
	logic sck_prev_q;
	logic csn_fall;
	logic csn_rise;
	logic sck_rise;
	logic sck_fall;
	prd_pkg::prd_spi_e st_q;
	prd_pkg::prd_spi_e st_d;
	logic [prd_pkg::CNT_W-1:0] bits_q;
	logic [prd_pkg::WORD_BITS-1:0] sh_in_q;
	logic [prd_pkg::WORD_BITS-1:0] sh_out_q;
	logic end_ok;
	logic poll;
	logic bad;

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			csn_prev_q <= 1'b1;
			sck_prev_q <= 1'b1;
		end
		else
		begin
			csn_prev_q <= csn_s;
			sck_prev_q <= sck_s;
		end

	assign csn_fall = csn_prev_q & ~csn_s;
	assign csn_rise = ~csn_prev_q & csn_s;
	assign sck_rise = ~sck_prev_q & sck_s & ~csn_s;
	assign sck_fall = sck_prev_q & ~sck_s & ~csn_s;

	always_comb
	begin
		st_d = st_q;
		case (st_q)
			prd_pkg::PRD_IDLE:
				if (csn_fall)
					st_d = prd_pkg::PRD_FRAME;
			prd_pkg::PRD_FRAME:
				if (csn_rise)
					st_d = prd_pkg::PRD_IDLE;
				else if (sck_rise && bits_q == FULL_CNT)
					st_d = prd_pkg::PRD_OVER;
			prd_pkg::PRD_OVER:
				if (csn_rise)
					st_d = prd_pkg::PRD_IDLE;
			default:
				st_d = prd_pkg::PRD_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
			st_q <= prd_pkg::PRD_IDLE;
		else
			st_q <= st_d;

	// a word counts only with exactly sixteen edges; a frame with none is a poll
	assign end_ok = csn_rise && st_q == prd_pkg::PRD_FRAME && bits_q == FULL_CNT;
	assign poll = csn_rise && st_q == prd_pkg::PRD_FRAME && bits_q == '0;
	assign bad = csn_rise && ((st_q == prd_pkg::PRD_FRAME && bits_q != '0 && bits_q != FULL_CNT)
		|| st_q == prd_pkg::PRD_OVER);

	// fault status
	logic uv_q;
	logic ot_q;
	logic lr_q;
	logic err_q;
	logic page_q;
	logic [3*NCH-1:0] rep;
	logic ff;

	assign ff = (|rep) | uv_q | ot_q | lr_q | err_q;

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			bits_q <= '0;
			sh_in_q <= '0;
			sh_out_q <= '0;
		end
		else if (csn_fall && st_q == prd_pkg::PRD_IDLE)
		begin
			// snapshot keeps the word steady while it is shifted out
			bits_q <= '0;
			sh_out_q <= status_word(page_q, ff, uv_q, lr_q, ot_q, rep);
		end
		else if (st_q == prd_pkg::PRD_FRAME)
		begin
			if (sck_rise && bits_q != FULL_CNT)
			begin
				sh_in_q <= {sh_in_q[prd_pkg::WORD_BITS-2:0], si_s};
				bits_q <= bits_q + ONE_CNT;
			end
			if (sck_fall)
				sh_out_q <= {sh_out_q[prd_pkg::WORD_BITS-2:0], 1'b0};
		end

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			serial_dout <= 1'b0;
			serial_dout_oe <= 1'b0;
		end
		else
		begin
			serial_dout <= sh_out_q[prd_pkg::WORD_BITS-1];
			serial_dout_oe <= ~csn_s;
		end

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			uv_q <= 1'b0;
			ot_q <= 1'b0;
			lr_q <= 1'b1;
			err_q <= 1'b0;
		end
		else
		begin
			uv_q <= uvd_s | uvr_s | (uv_q & ~end_ok);
			ot_q <= ot_s | (ot_q & ~end_ok);
			lr_q <= ~ext_high_s | (lr_q & ~end_ok);
			err_q <= bad | (err_q & ~end_ok);
		end

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
			page_q <= 1'b0;
		else if (!ext_high_s || poll)
			page_q <= 1'b0;
		else if (end_ok)
			page_q <= ~page_q;

	// writable registers
	logic [NCH-1:0] gate_sel_q;
	logic [NCH-1:0] mask_q;
	logic olm_q;
	prd_pkg::prd_cfg_s [NCH-1:0] cfg_q;
	logic [3:0] addr;
	logic is_cfg;

	assign addr = sh_in_q[prd_pkg::ADDR_MSB:prd_pkg::ADDR_LSB];
	assign is_cfg = sh_in_q[prd_pkg::CFG_FLAG_BIT];

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
		begin
			gate_sel_q <= '0;
			mask_q <= '0;
			olm_q <= 1'b0;
		end
		else if (end_ok && !is_cfg)
		begin
			if (addr == prd_pkg::ADDR_GATE)
				gate_sel_q <= sh_in_q[NCH-1:0];
			if (addr == prd_pkg::ADDR_MASK)
			begin
				mask_q <= sh_in_q[NCH-1:0];
				olm_q <= sh_in_q[prd_pkg::OLM_BIT];
			end
		end

	// selects 6 and 7 match no channel and change nothing
	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
			cfg_q <= {NCH{prd_pkg::CFG_RESET}};
		else if (end_ok && is_cfg)
			for (int i = 0; i < NCH; i++)
				if (sh_in_q[prd_pkg::CH_SEL_MSB:prd_pkg::CH_SEL_LSB] == 3'(i))
					cfg_q[i] <= to_cfg(sh_in_q);

	// channels
	logic [NCH-1:0] gate_vec;

	for (genvar c = 0; c < NCH; c++)
	begin : g_ch
		prd_tmr_if blank_if();
		prd_tmr_if retry_if();
		logic live;
		logic ol_en;
		logic gate_q;
		logic gate_dly_q;
		logic phase_on_q;
		logic block_q;
		logic [prd_pkg::FLT_BITS-1:0] flag_q;
		logic [prd_pkg::FLT_BITS-1:0] ok_q;
		logic [prd_pkg::FLT_BITS-1:0] hit;
		logic [prd_pkg::FLT_BITS-1:0] miss;
		logic [prd_pkg::FLT_BITS-1:0] seen;

		assign live = ~mask_q[c];
		assign ol_en = ~(olm_q & cfg_q[c].pulldown_disable);

		// comparators are judged only when a blank time runs out
		assign seen[prd_pkg::FLT_SB] = phase_on_q & bsd_s[c];
		assign seen[prd_pkg::FLT_SG] = ~phase_on_q & gsd_s[c];
		assign seen[prd_pkg::FLT_OL] = ~phase_on_q & old_s[c] & ol_en;
		assign hit = {prd_pkg::FLT_BITS{live & blank_if.done}} & seen;
		assign miss = {prd_pkg::FLT_BITS{live & blank_if.done}} & ~seen
			& {~phase_on_q, phase_on_q, ~phase_on_q};

		assign blank_if.start = gate_q ^ gate_dly_q;
		assign blank_if.load = blank_cycles(gate_q, cfg_q[c]);
		assign retry_if.start = hit[prd_pkg::FLT_SB] & cfg_q[c].retry_select[1];
		assign retry_if.load = cfg_q[c].retry_select[0] ? prd_pkg::TMR_W'(LONG_RETRY_CYC)
			: prd_pkg::TMR_W'(SHORT_RETRY_CYC);

		prd_timer u_blank (
			.mclk(mclk),
			.rst_b(rst_b),
			.tmr(blank_if)
		);

		prd_timer u_retry (
			.mclk(mclk),
			.rst_b(rst_b),
			.tmr(retry_if)
		);

		always_ff @(posedge mclk or negedge rst_b)
			if (!rst_b)
			begin
				gate_q <= 1'b0;
				gate_dly_q <= 1'b0;
				phase_on_q <= 1'b0;
			end
			else
			begin
				gate_q <= gate_sel_q[c] & ext_high_s & ~(block_q & live);
				gate_dly_q <= gate_q;
				if (blank_if.start)
					phase_on_q <= gate_q;
			end

		// with retry_select[1] clear, lockout only ends with the reset pin; with it set, a retry reopens the gate to test again
		always_ff @(posedge mclk or negedge rst_b)
			if (!rst_b)
				block_q <= 1'b0;
			else if (!ext_high_s)
				block_q <= 1'b0;
			else if (hit[prd_pkg::FLT_SB])
				block_q <= 1'b1;
			else if (retry_if.done && cfg_q[c].retry_select[1])
				block_q <= 1'b0;

		// a flag clears at the end of a read only once the fault was seen gone; a new hit wins
		always_ff @(posedge mclk or negedge rst_b)
			if (!rst_b)
			begin
				flag_q <= '0;
				ok_q <= '0;
			end
			else if (!ext_high_s)
			begin
				flag_q <= '0;
				ok_q <= '0;
			end
			else
			begin
				flag_q <= hit | (flag_q & ~(ok_q & {prd_pkg::FLT_BITS{end_ok}}));
				ok_q <= (ok_q | miss) & ~hit;
			end

		assign rep[prd_pkg::FLT_BITS*c +: prd_pkg::FLT_BITS] = flag_q & {prd_pkg::FLT_BITS{live}};
		assign gate_vec[c] = gate_q;
		assign battery_short_threshold[3*c +: 3] = cfg_q[c].battery_short_threshold;
		assign ground_short_threshold[c] = cfg_q[c].ground_short_threshold;
	end

	assign gate_drive_out = gate_vec;

	always_ff @(posedge mclk or negedge rst_b)
		if (!rst_b)
			pulldown_en <= '0;
		else
			for (int i = 0; i < NCH; i++)
				pulldown_en[i] <= ~cfg_q[i].pulldown_disable;
endmodule : prd_predriver

//--- tb/prd_host_model.sv
// prd_host_model: serial master standing in for the host controller
// assumes: mclk of the bench; half serial period of 10 mclk, well above the 8 mclk minimum
`timescale 1ns/1ps
module prd_host_model (
	input wire logic mclk,
	output logic csn_b,
	output logic sclk,
	output logic mosi,
	input wire logic miso
);
	initial
	begin
		csn_b = 1'b1;
		sclk = 1'b0;
		mosi = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge mclk);
	endtask : hold

	// n = 0 is a poll, n other than 0 or 16 a broken frame; clock stands low outside frames
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rd);
		rd = '0;
		@(posedge mclk);
		csn_b <= 1'b0;
		hold(10);
		for (int i = 0; i < n; i++)
		begin
			mosi <= w[15 - (i % 16)];
			hold(10);
			rd = {rd[14:0], miso};
			sclk <= 1'b1;
			hold(10);
			sclk <= 1'b0;
		end
		hold(10);
		csn_b <= 1'b1;
		// released line must not keep showing the last bit
		mosi <= ~mosi;
		hold(20);
	endtask : xfer
endmodule : prd_host_model

//--- tb/prd_predriver_monitor.sv
// prd_predriver_monitor: port-level assertions on the predriver register bank
// assumes: bound to prd_predriver; sync latency of 3-4 mclk on every pin
`timescale 1ns/1ps
module prd_predriver_monitor (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic serial_csn_b,
	input wire logic serial_clk,
	input wire logic serial_dout,
	input wire logic serial_dout_oe,
	input wire logic external_reset_low,
	input wire logic [prd_pkg::NUM_CH-1:0] gate_drive_out,
	input wire logic [prd_pkg::NUM_CH-1:0] pulldown_en,
	input wire logic [3*prd_pkg::NUM_CH-1:0] battery_short_threshold,
	input wire logic [prd_pkg::NUM_CH-1:0] ground_short_threshold
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	a_reset_values: assert property ($rose(rst_b) |-> ##2 (pulldown_en == '1 && battery_short_threshold == '0
		&& ground_short_threshold == '0 && gate_drive_out == '0)) else $error("reset value wrong");
	a_pin_reset_gate: assert property ((!external_reset_low)[*8] |-> gate_drive_out == '0)
		else $error("gate high while reset pin low");
	a_oe_idle_off: assert property (serial_csn_b[*8] |-> !serial_dout_oe)
		else $error("output enabled outside frame");
	a_oe_frame_on: assert property ((!serial_csn_b)[*8] |-> serial_dout_oe)
		else $error("output not enabled in frame");
	a_dout_holds: assert property (serial_clk[*8] |-> $stable(serial_dout))
		else $error("output bit moved while clock high");
	a_cfg_between_frames: assert property (!$stable({battery_short_threshold, ground_short_threshold})
		|-> serial_csn_b && $past(serial_csn_b, 3)) else $error("threshold changed inside frame");
	a_pulldown_after_frame: assert property (!$stable(pulldown_en) |-> serial_csn_b && $past(serial_csn_b, 3))
		else $error("pulldown changed inside frame");
	a_gate0_after_frame: assert property ($rose(gate_drive_out[0]) |-> serial_csn_b && $past(serial_csn_b, 4))
		else $error("gate rose inside frame");

	c_frame: cover property ($rose(serial_dout_oe));
	c_gate_on: cover property ($rose(gate_drive_out[0]));
	c_pin_reset: cover property ($fell(external_reset_low));
endmodule : prd_predriver_monitor

bind prd_predriver prd_predriver_monitor i_prd_predriver_monitor (.mclk(mclk), .rst_b(rst_b),
	.serial_csn_b(serial_csn_b), .serial_clk(serial_clk), .serial_dout(serial_dout),
	.serial_dout_oe(serial_dout_oe), .external_reset_low(external_reset_low), .gate_drive_out(gate_drive_out),
	.pulldown_en(pulldown_en), .battery_short_threshold(battery_short_threshold),
	.ground_short_threshold(ground_short_threshold));

//--- tb/testbench.sv
// testbench: self-checking bench for the predriver register bank
// assumes: host model drives the serial pins; select-0 blank counts and both retry counts shortened
`timescale 1ns/1ps
module testbench;
	logic mclk, rst_b, csn_b, sclk, din, dout, dout_oe, ext_rst, vdd_uv, vreg_uv, ot;
	logic [5:0] bsd, gsd, old, gate, pden, gst;
	logic [17:0] bst;
	logic [15:0] rd;
	int fail_count, cmp_count;

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	prd_host_model host (.mclk(mclk), .csn_b(csn_b), .sclk(sclk), .mosi(din), .miso(dout));

	prd_predriver #(.SHORT_RETRY_CYC(40), .LONG_RETRY_CYC(60), .OFF_BLANK0_CYC(10), .ON_BLANK0_CYC(3))
	i_prd_predriver (.mclk(mclk), .rst_b(rst_b), .serial_csn_b(csn_b), .serial_clk(sclk), .serial_din(din),
		.serial_dout(dout), .serial_dout_oe(dout_oe), .external_reset_low(ext_rst), .vdd_undervoltage(vdd_uv),
		.vreg_undervoltage(vreg_uv), .overtemp_detect(ot), .battery_short_detect(bsd),
		.ground_short_detect(gsd), .open_load_detect(old), .gate_drive_out(gate), .pulldown_en(pden),
		.battery_short_threshold(bst), .ground_short_threshold(gst));

	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	task automatic t_reset_and_pages();
		chk({gate, pden, gst}, {6'h00, 6'h3F, 6'h00});
		chk(bst, 18'h0);
		host.xfer(16'h0000, 16, rd);
		chk(rd, 16'hA000);
		host.xfer(16'h0000, 16, rd);
		chk(rd, 16'h0800);
		// a short frame must neither write nor advance the page
		host.xfer(16'h1001, 8, rd);
		chk(gate, 6'h00);
		host.xfer(16'h0000, 16, rd);
		chk(rd, 16'h8000);
		host.xfer(16'h1015, 16, rd);
		chk(rd, 16'h0800);
		chk(gate, 6'h15);
	endtask : t_reset_and_pages

	task automatic t_config();
		for (int c = 0; c < 8; c++)
		begin
			host.xfer(16'h9000 | 16'(c << 1) | 16'(c & 1), 16, rd);
			chk({bst[5:3], gst[1]}, 18'({3'(c), 1'(c & 1)}));
		end
		host.xfer(16'hA100, 16, rd);
		chk(pden, 6'h3B);
		host.xfer(16'hE00F, 16, rd);
		host.xfer(16'hF10F, 16, rd);
		chk({pden, bst}, {6'h3B, 18'h00038});
	endtask : t_config

	task automatic t_faults();
		@(posedge mclk);
		old[4] <= 1'b1;
		host.xfer(16'h0000, 0, rd);
		host.xfer(16'h1005, 16, rd);
		chk(rd, 16'h0000);
		host.xfer(16'h0000, 16, rd);
		chk(rd, 16'h8808);
		host.xfer(16'h5010, 16, rd);
		chk(rd, 16'h8000);
		host.xfer(16'h0000, 16, rd);
		chk(rd, 16'h0800);
		vdd_uv <= 1'b1;
		ot <= 1'b1;
		host.xfer(16'h0000, 16, rd);
		chk(rd, 16'hD000);
		vdd_uv <= 1'b0;
		ot <= 1'b0;
		vreg_uv <= 1'b1;
		host.xfer(16'h0000, 16, rd);
		// overtemp was still present after the last fault reset, so it stays latched
		chk(rd, 16'hD800);
		vreg_uv <= 1'b0;
		host.xfer(16'h0000, 16, rd);
		chk(rd, 16'hC000);
	endtask : t_faults

	task automatic t_lockout_and_pin();
		@(posedge mclk);
		bsd[0] <= 1'b1;
		host.xfer(16'h1004, 16, rd);
		host.xfer(16'h1005, 16, rd);
		host.hold(50);
		chk(gate, 6'h04);
		bsd[0] <= 1'b0;
		ext_rst <= 1'b0;
		host.hold(12);
		chk(gate, 6'h00);
		ext_rst <= 1'b1;
		host.hold(12);
		chk(gate, 6'h05);
		host.xfer(16'h0000, 16, rd);
		chk(rd, 16'hA000);
	endtask : t_lockout_and_pin

	task automatic t_retry_ground();
		host.xfer(16'h9800, 16, rd);
		chk(rd, 16'h0800);
		chk({bst[5:3], gst[1]}, 18'h0);
		bsd[1] <= 1'b1;
		host.xfer(16'h1007, 16, rd);
		chk(rd, 16'h0000);
		chk(gate[1], 1'b0);
		// a short retry reopens the gate by itself; running out of the bound is a miss
		for (int i = 0; i < 200 && gate[1] !== 1'b1; i++)
			@(posedge mclk);
		chk(gate[1], 1'b1);
		host.xfer(16'h5040, 16, rd);
		chk(rd, 16'h8800);
		old[2] <= 1'b1;
		gsd[0] <= 1'b1;
		host.xfer(16'h1000, 16, rd);
		chk(rd, 16'h8010);
		host.xfer(16'h0000, 16, rd);
		chk(rd, 16'h8800);
		// channel 2 has its pulldown off and the open-load mask set: no open-load flag
		host.xfer(16'h0000, 16, rd);
		chk(rd, 16'h8014);
	endtask : t_retry_ground

	initial
	begin
		rst_b = 1'b0;
		ext_rst = 1'b1;
		{vdd_uv, vreg_uv, ot} = 3'h0;
		{bsd, gsd, old} = '0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		host.hold(10);
		t_reset_and_pages();
		t_config();
		t_faults();
		t_lockout_and_pin();
		t_retry_ground();
		summarize();
	end

	initial
	begin
		repeat (100000) @(posedge mclk);
		fail_count++;
		summarize();
	end
endmodule : testbench
